// >>> tbcm_pkg.sv
/*
  Package for the three-decade BCD counter with multiplexed display output.
  Assumes a single 125 MHz system clock; all pins are sampled into that domain.
*/
// Summary of operation
// R1: Scan tick from internal divider, or from external scan clock when one is selected.
// R2: Digit selector advances on each scan tick.
// R3: One overflow pulse per 1000 counted input pulses.
// R4: Count clear zeroes all three decades and resets the scanner.
// R5: While clear is high the scanner points at the first digit.
// R6: While clear is high all digit selects are inactive, scan stopped.
// R7: Count inhibit high blocks counting and keeps the count.
// R8: Latch enable rising captures counters; held while latch enable stays high.
// R9: Latched value survives a clear if latch enable is high throughout.
// R10: Decades advance on input clock falling edge, carries chained in one step.
// R11: Latched digits appear one at a time on one four-bit bus.
// R12: BCD active high; digit selects active low, only the shown digit asserted.
// R13: Scan order digit 0, 1, 2, back to 0, one step per tick.
package tbcm_pkg;
    // ==========================================================
    // Timing and reset values
    localparam int unsigned TBCM_CLK_HZ = 125_000_000;
    localparam int unsigned TBCM_SCAN_HZ = 1000;
    localparam int unsigned TBCM_SCAN_CYCLES = TBCM_CLK_HZ / TBCM_SCAN_HZ;
    localparam logic [3:0] TBCM_DIGIT_RST = 4'h0;
    localparam logic [3:0] TBCM_DIGIT_MAX = 4'h9;
    localparam logic [2:0] TBCM_SEL_OFF_N = 3'h7;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        TBCM_POS0 = 2'b00,
        TBCM_POS1 = 2'b01,
        TBCM_POS2 = 2'b10
    } tbcm_pos_e;

    typedef struct packed {
        logic [3:0] d2;
        logic [3:0] d1;
        logic [3:0] d0;
    } tbcm_count_s;
endpackage

// >>> tbcm_counter.sv
/*
  Three-decade BCD counter, output latches and digit multiplexer.
  Assumes all pin inputs are asynchronous to SYS_CLK and slower than it.
*/
module tbcm_counter
    import tbcm_pkg::*;
#(
    parameter int unsigned SCAN_CYCLES = TBCM_SCAN_CYCLES
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    // Count and control pins
    input wire logic COUNT_CLK,
    input wire logic COUNT_CLEAR,
    input wire logic COUNT_INHIBIT,
    input wire logic LATCH_EN,
    // Scan source selection
    input wire logic EXT_SCAN_SEL,
    input wire logic EXT_SCAN_CLK,
    // Display and cascade outputs
    output logic [3:0] BCD_OUT,
    output logic [2:0] DIGIT_SEL_N,
    output logic OVERFLOW
);

    // ==========================================================
    // Input synchronisers
    logic [1:0] clk_s_reg, clr_s_reg, inh_s_reg, le_s_reg, esel_s_reg, eclk_s_reg;
    logic clk_d_reg, le_d_reg, eclk_d_reg;
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            clk_s_reg <= 2'h0;
            clr_s_reg <= 2'h0;
            inh_s_reg <= 2'h0;
            le_s_reg <= 2'h0;
            esel_s_reg <= 2'h0;
            eclk_s_reg <= 2'h0;
            clk_d_reg <= 1'b0;
            le_d_reg <= 1'b0;
            eclk_d_reg <= 1'b0;
        end else begin
            clk_s_reg <= {clk_s_reg[0], COUNT_CLK};
            clr_s_reg <= {clr_s_reg[0], COUNT_CLEAR};
            inh_s_reg <= {inh_s_reg[0], COUNT_INHIBIT};
            le_s_reg <= {le_s_reg[0], LATCH_EN};
            esel_s_reg <= {esel_s_reg[0], EXT_SCAN_SEL};
            eclk_s_reg <= {eclk_s_reg[0], EXT_SCAN_CLK};
            clk_d_reg <= clk_s_reg[1];
            le_d_reg <= le_s_reg[1];
            eclk_d_reg <= eclk_s_reg[1];
        end
    end

    wire clr = clr_s_reg[1];
    wire le = le_s_reg[1];
    // Falling edge of the counted clock, gated by inhibit
    wire cnt_fall = clk_d_reg & ~clk_s_reg[1] & ~inh_s_reg[1]; // R10 R7
    wire le_rise = le & ~le_d_reg;

    // ==========================================================
    // Decade chain
    function automatic logic [3:0] bcd_inc(input logic [3:0] d);
        bcd_inc = (d == TBCM_DIGIT_MAX) ? TBCM_DIGIT_RST : d + 4'h1;
    endfunction

    tbcm_count_s cnt_reg, cnt_next;
    wire c0 = cnt_reg.d0 == TBCM_DIGIT_MAX;
    wire c1 = c0 && cnt_reg.d1 == TBCM_DIGIT_MAX;
    wire c2 = c1 && cnt_reg.d2 == TBCM_DIGIT_MAX;
    // Carries computed combinationally so all decades step on the same edge
    assign cnt_next.d0 = bcd_inc(cnt_reg.d0); // R10
    assign cnt_next.d1 = c0 ? bcd_inc(cnt_reg.d1) : cnt_reg.d1; // R10
    assign cnt_next.d2 = c1 ? bcd_inc(cnt_reg.d2) : cnt_reg.d2; // R10

    logic ovf_reg;
    // Clear has priority; overflow is a one-cycle pulse on 999 -> 000
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt_reg <= '0;
            ovf_reg <= 1'b0;
        end else if (clr) begin
            cnt_reg <= '0; // R4
            ovf_reg <= 1'b0;
        end else begin
            if (cnt_fall) cnt_reg <= cnt_next; // R7
            ovf_reg <= cnt_fall & c2; // R3
        end
    end

    // ==========================================================
    // Output latches: transparent-on-rise capture, frozen while enable high.
    // Clear does not touch them, so a held value survives a count clear.
    tbcm_count_s lat_reg;
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            lat_reg <= '0;
        end else if (!le || le_rise) begin
            lat_reg <= cnt_reg; // R8 R9
        end
    end

    // ==========================================================
    // Scan tick: internal divider or external scan clock rising edge
    logic [$clog2(SCAN_CYCLES)-1:0] div_reg;
    wire div_end = div_reg == ($clog2(SCAN_CYCLES))'(SCAN_CYCLES - 1);
    wire ext_rise = eclk_s_reg[1] & ~eclk_d_reg;
    wire scan_tick = esel_s_reg[1] ? ext_rise : div_end; // R1
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            div_reg <= '0;
        end else if (clr || div_end) begin
            div_reg <= '0; // R6
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    tbcm_pos_e pos_reg, pos_next;
    always_comb begin
        unique case (pos_reg)
            TBCM_POS0: pos_next = TBCM_POS1; // R13
            TBCM_POS1: pos_next = TBCM_POS2;
            TBCM_POS2: pos_next = TBCM_POS0;
            default: pos_next = TBCM_POS0;
        endcase
    end
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pos_reg <= TBCM_POS0;
        end else if (clr) begin
            pos_reg <= TBCM_POS0; // R5
        end else if (scan_tick) begin
            pos_reg <= pos_next; // R2
        end
    end

    // ==========================================================
    // Output registers: one digit at a time, select active low
    wire [3:0] mux_digit = (pos_reg == TBCM_POS0) ? lat_reg.d0 :
                           (pos_reg == TBCM_POS1) ? lat_reg.d1 : lat_reg.d2; // R11
    wire [2:0] sel_n = clr ? TBCM_SEL_OFF_N : ~(3'h1 << pos_reg); // R12 R6
    logic [3:0] bcd_reg;
    logic [2:0] sel_reg;
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bcd_reg <= TBCM_DIGIT_RST;
            sel_reg <= TBCM_SEL_OFF_N;
        end else begin
            bcd_reg <= mux_digit; // R11
            sel_reg <= sel_n; // R12
        end
    end
    assign BCD_OUT = bcd_reg;
    assign DIGIT_SEL_N = sel_reg;
    assign OVERFLOW = ovf_reg;

    // ==========================================================
    // Assertions
    property p_ovf;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        ovf_reg |-> cnt_reg == '0 && $past(cnt_reg) == 12'h999;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow without wrap"); // R3
    property p_clr;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        clr |=> cnt_reg == '0 && pos_reg == TBCM_POS0;
    endproperty
    a_clr: assert property (p_clr) else $error("clear did not reset"); // R4
    property p_pos;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        clr && $past(clr) |-> pos_reg == TBCM_POS0;
    endproperty
    a_pos: assert property (p_pos) else $error("scanner moved in clear"); // R5
    property p_seloff;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        clr |=> sel_reg == TBCM_SEL_OFF_N;
    endproperty
    a_seloff: assert property (p_seloff) else $error("select active in clear"); // R6
    property p_inh;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        inh_s_reg[1] && !clr |=> $stable(cnt_reg);
    endproperty
    a_inh: assert property (p_inh) else $error("count changed while inhibited"); // R7
    property p_hold;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        le && $past(le) |=> $stable(lat_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("latch changed while held"); // R8 R9
    property p_step;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        cnt_fall && !clr |=> cnt_reg.d0 == bcd_inc($past(cnt_reg.d0));
    endproperty
    a_step: assert property (p_step) else $error("units decade missed edge"); // R10
    property p_scan;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        scan_tick && !clr && pos_reg == TBCM_POS2 |=> pos_reg == TBCM_POS0;
    endproperty
    a_scan: assert property (p_scan) else $error("scan did not wrap"); // R13 R2
    property p_onehot;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        !clr |=> $countones(~sel_reg) == 1;
    endproperty
    a_onehot: assert property (p_onehot) else $error("select not one-hot"); // R12
    property p_cap;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        le_rise |=> lat_reg == $past(cnt_reg);
    endproperty
    a_cap: assert property (p_cap) else $error("latch missed capture"); // R8
    property p_ovf_once;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        ovf_reg |=> !ovf_reg;
    endproperty
    a_ovf_once: assert property (p_ovf_once) else $error("overflow wider than one cycle"); // R3
    property p_scan_stop;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        clr |=> div_reg == '0;
    endproperty
    a_scan_stop: assert property (p_scan_stop) else $error("scan divider ran in clear"); // R6
    // Units select must carry the units latch of the cycle before, as both outputs are registered together
    property p_units_shown;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        sel_reg == 3'h6 |-> bcd_reg == $past(lat_reg.d0);
    endproperty
    a_units_shown: assert property (p_units_shown) else $error("wrong digit under units select"); // R11 R12
    c_ovf: cover property (@(posedge SYS_CLK) ovf_reg);
    c_ext: cover property (@(posedge SYS_CLK) esel_s_reg[1] && ext_rise);
    c_held: cover property (@(posedge SYS_CLK) le && clr);
    c_cap: cover property (@(posedge SYS_CLK) le_rise);
endmodule

// >>> tbcm_display_model.sv
/*
  Display and cascade partner: keeps the digit shown under each active select.
  Assumes the counter outputs settle after each rising edge of sys_clk.
*/
module tbcm_display_model
    import tbcm_pkg::*;
(
    // Counter outputs
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [3:0] bcd,
    input wire logic [2:0] sel_n,
    input wire logic ovf,
    // Observed results
    output tbcm_count_s shown,
    output int ovf_cnt,
    output int multi_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Capture
    // Two selects low at once would smear digits, so it is counted
    initial begin
        shown = '0;
        ovf_cnt = 0;
        multi_cnt = 0;
    end
    // Outputs are unknown before the first reset edge, so nothing is taken during reset
    always @(posedge sys_clk) begin
        if (arst_n) begin
            case (sel_n)
                3'h6: shown.d0 <= bcd;
                3'h5: shown.d1 <= bcd;
                3'h3: shown.d2 <= bcd;
                3'h7: ;
                default: multi_cnt <= multi_cnt + 1;
            endcase
            if (ovf === 1'b1) ovf_cnt <= ovf_cnt + 1;
        end
    end
endmodule

// >>> tbcm_counter_tb_top.sv
/*
  Self-checking bench for the three-decade counter with a behavioural count model.
  Assumes SCAN_CYCLES of 8 and inputs driven on the falling edge of sys_clk.
*/
module tbcm_counter_tb_top
    import tbcm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, arst_n = 0, cnt_clk = 0, clr = 0, inh = 0, lat_en = 0, ext_sel = 0, ext_clk = 0;
    logic [3:0] bcd;
    logic [2:0] sel_n, sel_hold;
    logic ovf;
    tbcm_count_s shown;
    int ovf_cnt, multi_cnt, error_cnt = 0, compares = 0, cnt = 0, lat = 0, exp_ovf = 0, n;
    integer seed = 45;

    // ==========================================================
    // Clock, design and partner
    initial forever #4 sys_clk = ~sys_clk;
    tbcm_counter #(.SCAN_CYCLES(8)) uut (.SYS_CLK(sys_clk), .ARST_N(arst_n), .COUNT_CLK(cnt_clk),
        .COUNT_CLEAR(clr), .COUNT_INHIBIT(inh), .LATCH_EN(lat_en), .EXT_SCAN_SEL(ext_sel),
        .EXT_SCAN_CLK(ext_clk), .BCD_OUT(bcd), .DIGIT_SEL_N(sel_n), .OVERFLOW(ovf));
    tbcm_display_model disp (.sys_clk(sys_clk), .arst_n(arst_n), .bcd(bcd), .sel_n(sel_n), .ovf(ovf),
        .shown(shown), .ovf_cnt(ovf_cnt), .multi_cnt(multi_cnt));

    // ==========================================================
    // Tasks
    task check(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function logic [11:0] digits(input int v);
        return {4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction
    // Model follows each pulse; phases of 4 clocks beat the synchroniser
    task pulse(input int k);
        repeat (k) begin
            @(negedge sys_clk) cnt_clk = 1;
            repeat (4) @(negedge sys_clk);
            cnt_clk = 0;
            repeat (4) @(negedge sys_clk);
            if (!inh && !clr) begin
                cnt = (cnt + 1) % 1000;
                if (cnt == 0) exp_ovf++;
            end
            if (!lat_en) lat = cnt;
        end
    endtask
    // A full scan is 24 cycles, so 40 leaves margin for the sync delay
    task scan_check;
        repeat (40) @(negedge sys_clk);
        check(shown, digits(lat));
    endtask
    task test_done;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(negedge sys_clk);
        arst_n = 1;
        clr = 1;
        repeat (20) @(negedge sys_clk);
        check({9'h0, sel_n}, 12'h007);
        clr = 0;
        for (n = 0; n < 30 && sel_n === 3'h7; n++) @(negedge sys_clk);
        check({9'h0, sel_n}, 12'h006);
        $display("test clear done");
        repeat (3) begin
            pulse(5 + {$random(seed)} % 20);
            scan_check;
        end
        check(12'(multi_cnt), 12'h000);
        pulse(456 - cnt);
        scan_check;
        pulse(546);
        scan_check;
        check(12'(ovf_cnt), 12'(exp_ovf));
        $display("test count done");
        inh = 1;
        pulse(7);
        inh = 0;
        scan_check;
        lat_en = 1;
        pulse(9);
        scan_check;
        clr = 1;
        cnt = 0;
        repeat (10) @(negedge sys_clk);
        clr = 0;
        scan_check;
        lat_en = 0;
        lat = cnt;
        scan_check;
        $display("test latch done");
        // External scan must not step without edges of its own clock
        ext_sel = 1;
        pulse(3);
        sel_hold = sel_n;
        repeat (40) @(negedge sys_clk);
        check({9'h0, sel_n}, {9'h0, sel_hold});
        repeat (6) begin
            repeat (4) @(negedge sys_clk);
            ext_clk = ~ext_clk;
        end
        repeat (8) @(negedge sys_clk);
        check(shown, digits(lat));
        $display("test scan done");
        test_done;
    end

    // Watchdog, about five times the expected run
    initial begin
        #400000;
        error_cnt++;
        test_done;
    end
endmodule
